// ---- shared/dmb_pkg.sv ----
// dmb_pkg: constants and carrier types for the data memory bus port
// assumes one clock domain (mclk, 25 MHz) and an active-low async reset
package dmb_pkg;
  localparam int DMB_ADDR_W = 32;
  localparam int DMB_DATA_W = 40;
  localparam int DMB_BANKS = 4;
  localparam int DMB_SHIFT_W = 5;
  localparam int DMB_WORD_LSB = 8;
  localparam int DMB_WORD_W = 32;
  // clock rate and cycle figures
  localparam int DMB_CLK_HZ = 25000000;
  localparam int DMB_SYNC_STAGES = 2;
  // program memory fetch address after reset (plain default)
  localparam logic [23:0] DMB_RESET_VECTOR = 24'h000008;
  localparam logic [DMB_ADDR_W-1:0] DMB_ADDR_RST = 32'h00000000;
  localparam logic [DMB_DATA_W-1:0] DMB_DATA_RST = 40'h0000000000;
  localparam logic [DMB_BANKS-1:0] DMB_SEL_IDLE = 4'hF;
  localparam logic [DMB_SHIFT_W-1:0] DMB_NO_PAGES = 5'h00;

  typedef enum logic [1:0] {DMB_IDLE, DMB_ACCESS, DMB_GRANTED} dmb_state_t;

  typedef struct packed {
    logic write;
    logic [DMB_ADDR_W-1:0] addr;
    logic [DMB_DATA_W-1:0] wdata;
  } dmb_req_t;

  typedef struct packed {
    logic [DMB_SHIFT_W-1:0] pageShift;
    logic [DMB_SHIFT_W-1:0] bankShift;
    logic [DMB_BANKS-1:0] bankEnable;
  } dmb_cfg_t;

  typedef struct packed {
    logic [DMB_ADDR_W-1:0] addr;
    logic [DMB_DATA_W-1:0] data;
    logic [DMB_BANKS-1:0] bankSelN;
    logic readN;
    logic writeN;
  } dmb_pins_t;
endpackage

// ---- logic/dmb_sync.sv ----
// dmb_sync: two-flop synchroniser for one asynchronous level
// assumes the input may change at any time relative to mclk
`timescale 1ns/1ns
module dmb_sync
  import dmb_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_reg;
  logic sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= asyncIn;
      sync_reg <= meta_reg;
    end
  end

  assign syncOut = sync_reg;
endmodule

// ---- logic/dmb_data_memory_bus_interface.sv ----
// dmb_data_memory_bus_interface: external data memory port of the processor
// assumes core requests, config, ack and float control are synchronous to mclk;
// the bus request pin is asynchronous and is synchronised here
//
// Overview of operation
// RULE1 - read strobe low throughout every read access
// RULE2 - write strobe low throughout every write access
// RULE3 - each clock with acknowledge high adds wait
// RULE4 - page output flags access into new page
// RULE5 - page size from config; zero means none
// RULE6 - float control releases address, data, selects, strobes
// RULE7 - float during access halts, access stays pending
// RULE8 - party holds acknowledge low on float release
// RULE9 - float asserted only during an access cycle
// RULE10 - one cycle per clock; waits count clocks
// RULE11 - clock runs continuously at fixed frequency
// RULE12 - reset defines state; fetch starts at vector
// RULE13 - reset held low during power-up
// RULE14 - bus request: finish cycle, halt, float, grant
// RULE15 - grant held low while request stays low
// RULE16 - request released: ungrant, drive, resume
// RULE17 - drive 32-bit data memory address
// RULE18 - 40-bit data, 32-bit words on 39-8
// RULE19 - four bank selects decoded early from address
// RULE20 - control pins active low, idle deasserted
`timescale 1ns/1ns
module dmb_data_memory_bus_interface
  import dmb_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  // core side
  input wire logic coreReqValid,
  input dmb_req_t coreReq,
  output logic coreReqReady,
  output logic coreRespValid,
  output logic [DMB_DATA_W-1:0] coreRespData,
  output logic coreHalt,
  output logic fetchStart,
  output logic [23:0] fetchAddr,
  input dmb_cfg_t cfg,
  // external pins
  output dmb_pins_t dmOut,
  output logic dmAddrOe,
  output logic dmDataOe,
  output logic dmCtrlOe,
  input wire logic [DMB_DATA_W-1:0] dmDataIn,
  input wire logic dm_acknowledge_n,
  input wire logic dm_float_ctrl_n,
  input wire logic bus_request_n,
  output logic bus_grant_n,
  output logic dm_page_cross
);
  dmb_state_t state_reg, state_next;
  dmb_req_t cur_reg, cur_next;
  dmb_pins_t pins_reg, pins_next;
  logic addrOe_reg, addrOe_next;
  logic dataOe_reg, dataOe_next;
  logic ctrlOe_reg, ctrlOe_next;
  logic ready_reg, ready_next;
  logic respValid_reg, respValid_next;
  logic [DMB_DATA_W-1:0] respData_reg, respData_next;
  logic halt_reg, halt_next;
  logic grantN_reg, grantN_next;
  logic page_reg, page_next;
  logic [DMB_ADDR_W-1:0] lastAddr_reg, lastAddr_next;
  logic lastValid_reg, lastValid_next;
  logic started_reg, started_next;
  logic fetchStart_reg, fetchStart_next;
  logic busReqN;
  logic take;
  logic floatOn;
  logic [DMB_BANKS-1:0] decodedSelN;
  logic crossing;

  // bus request is asynchronous, so it is synchronised before use
  dmb_sync #(.RST_VAL(1'b1)) u_brSync (
    .mclk(mclk),
    .resetn(resetn),
    .asyncIn(bus_request_n),
    .syncOut(busReqN)
  );

  assign floatOn = !dm_float_ctrl_n;
  assign take = (state_reg == DMB_IDLE) && ready_reg && coreReqValid && busReqN;

  // bank decode: bank index is the address above bankShift; beyond bank 3 selects none
  always_comb begin
    logic [DMB_ADDR_W-1:0] idx;
    idx = coreReq.addr >> cfg.bankShift;
    decodedSelN = DMB_SEL_IDLE;
    if (idx < DMB_ADDR_W'(DMB_BANKS)) begin
      decodedSelN[idx[1:0]] = !cfg.bankEnable[idx[1:0]]; // see RULE19
    end
  end

  // page crossing only when pages are defined (nonzero size)
  always_comb begin
    crossing = 1'b0;
    if (cfg.pageShift != DMB_NO_PAGES && lastValid_reg) begin // see RULE5
      crossing = (coreReq.addr >> cfg.pageShift) != (lastAddr_reg >> cfg.pageShift); // see RULE4
    end
  end

  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    pins_next = pins_reg;
    addrOe_next = addrOe_reg;
    dataOe_next = dataOe_reg;
    ctrlOe_next = ctrlOe_reg;
    ready_next = 1'b0;
    respValid_next = 1'b0;
    respData_next = respData_reg;
    halt_next = halt_reg;
    grantN_next = grantN_reg;
    page_next = page_reg;
    lastAddr_next = lastAddr_reg;
    lastValid_next = lastValid_reg;
    unique case (state_reg)
      DMB_IDLE: begin
        pins_next.readN = 1'b1; // see RULE20
        pins_next.writeN = 1'b1;
        pins_next.bankSelN = DMB_SEL_IDLE;
        page_next = 1'b0;
        dataOe_next = 1'b0;
        addrOe_next = !floatOn; // see RULE6
        ctrlOe_next = !floatOn;
        halt_next = 1'b0;
        if (!busReqN) begin
          // idle counts as a finished cycle: halt and hand the bus over
          state_next = DMB_GRANTED; // see RULE14
          addrOe_next = 1'b0;
          ctrlOe_next = 1'b0;
          halt_next = 1'b1;
          grantN_next = 1'b0; // see RULE15
        end else if (take) begin
          state_next = DMB_ACCESS;
          cur_next = coreReq;
          pins_next.addr = coreReq.addr; // see RULE17
          pins_next.data = coreReq.wdata; // see RULE18
          pins_next.bankSelN = decodedSelN; // see RULE19
          pins_next.readN = coreReq.write; // see RULE1
          pins_next.writeN = !coreReq.write; // see RULE2
          dataOe_next = coreReq.write && !floatOn;
          page_next = crossing; // see RULE4
          lastAddr_next = coreReq.addr;
          lastValid_next = 1'b1;
        end else begin
          ready_next = 1'b1;
        end
      end
      DMB_ACCESS: begin
        // floated pins stay released, and the access stays open until release
        addrOe_next = !floatOn; // see RULE6
        ctrlOe_next = !floatOn;
        dataOe_next = cur_reg.write && !floatOn;
        halt_next = floatOn; // see RULE7
        // the pins are sampled only while driven; the far side acks after release
        if (!floatOn && ctrlOe_reg && !dm_acknowledge_n) begin // see RULE3
          state_next = DMB_IDLE;
          respValid_next = 1'b1;
          if (!cur_reg.write) begin
            respData_next = dmDataIn;
          end
          pins_next.readN = 1'b1; // see RULE1
          pins_next.writeN = 1'b1; // see RULE2
          pins_next.bankSelN = DMB_SEL_IDLE; // see RULE20
          page_next = 1'b0;
          dataOe_next = 1'b0;
          ready_next = busReqN;
        end
      end
      DMB_GRANTED: begin
        addrOe_next = 1'b0; // see RULE14
        dataOe_next = 1'b0;
        ctrlOe_next = 1'b0;
        halt_next = 1'b1;
        if (busReqN) begin
          state_next = DMB_IDLE; // see RULE16
          grantN_next = 1'b1;
          halt_next = 1'b0;
          addrOe_next = !floatOn;
          ctrlOe_next = !floatOn;
        end
      end
      default: begin
        state_next = DMB_IDLE;
      end
    endcase
  end

  // fetch from the reset vector begins one cycle after reset release
  always_comb begin
    started_next = 1'b1;
    fetchStart_next = !started_reg; // see RULE12
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin // see RULE12
      state_reg <= DMB_IDLE;
      cur_reg <= '0;
      pins_reg <= '{addr: DMB_ADDR_RST, data: DMB_DATA_RST, bankSelN: DMB_SEL_IDLE,
                    readN: 1'b1, writeN: 1'b1};
      addrOe_reg <= 1'b0;
      dataOe_reg <= 1'b0;
      ctrlOe_reg <= 1'b0;
      ready_reg <= 1'b0;
      respValid_reg <= 1'b0;
      respData_reg <= DMB_DATA_RST;
      halt_reg <= 1'b0;
      grantN_reg <= 1'b1;
      page_reg <= 1'b0;
      lastAddr_reg <= DMB_ADDR_RST;
      lastValid_reg <= 1'b0;
      started_reg <= 1'b0;
      fetchStart_reg <= 1'b0;
    end else begin // see RULE10
      state_reg <= state_next;
      cur_reg <= cur_next;
      pins_reg <= pins_next;
      addrOe_reg <= addrOe_next;
      dataOe_reg <= dataOe_next;
      ctrlOe_reg <= ctrlOe_next;
      ready_reg <= ready_next;
      respValid_reg <= respValid_next;
      respData_reg <= respData_next;
      halt_reg <= halt_next;
      grantN_reg <= grantN_next;
      page_reg <= page_next;
      lastAddr_reg <= lastAddr_next;
      lastValid_reg <= lastValid_next;
      started_reg <= started_next;
      fetchStart_reg <= fetchStart_next;
    end
  end

  assign coreReqReady = ready_reg;
  assign coreRespValid = respValid_reg;
  assign coreRespData = respData_reg;
  assign coreHalt = halt_reg;
  assign fetchStart = fetchStart_reg;
  assign fetchAddr = DMB_RESET_VECTOR;
  assign dmOut = pins_reg;
  assign dmAddrOe = addrOe_reg;
  assign dmDataOe = dataOe_reg;
  assign dmCtrlOe = ctrlOe_reg;
  assign bus_grant_n = grantN_reg;
  assign dm_page_cross = page_reg;
endmodule

// ---- tb/dmb_data_memory_bus_interface_assertions.sv ----
// checker: pin relations of the data memory port
// assumes it is bound into the port module, one clock, async low reset
`timescale 1ns/1ns
module dmb_data_memory_bus_interface_assertions
  import dmb_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input dmb_pins_t dmOut,
  input wire logic dmAddrOe,
  input wire logic dmCtrlOe,
  input wire logic dm_acknowledge_n,
  input wire logic dm_float_ctrl_n,
  input wire logic bus_request_n,
  input wire logic bus_grant_n,
  input wire logic coreRespValid,
  input wire logic coreReqReady,
  input wire logic coreHalt
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic strb;
  assign strb = !dmOut.readN || !dmOut.writeN;
  property p_done; strb && dmCtrlOe && dm_float_ctrl_n && !dm_acknowledge_n
    |=> !strb && coreRespValid; endproperty
  a_done: assert property (p_done) else $error("strobe outlived ack");
  property p_wait; strb && dmCtrlOe && dm_acknowledge_n |=> strb; endproperty
  a_wait: assert property (p_wait) else $error("strobe ended without ack");
  property p_flt; !dm_float_ctrl_n |=> !dmAddrOe && !dmCtrlOe; endproperty
  a_flt: assert property (p_flt) else $error("pins driven while floated");
  property p_hlt; !dm_float_ctrl_n |=> !coreRespValid; endproperty
  a_hlt: assert property (p_hlt) else $error("access done while floated");
  property p_gnt; !bus_grant_n |-> !dmAddrOe && !dmCtrlOe && coreHalt && !coreReqReady;
  endproperty
  a_gnt: assert property (p_gnt) else $error("granted but still active");
  property p_hold; !bus_grant_n && !bus_request_n |=> !bus_grant_n; endproperty
  a_hold: assert property (p_hold) else $error("grant dropped early");
  property p_ungnt; $rose(bus_request_n) && !bus_grant_n |-> ##[1:4] bus_grant_n;
  endproperty
  a_ungnt: assert property (p_ungnt) else $error("grant not released");
  property p_idle; coreReqReady |-> dmOut.readN && dmOut.writeN
    && dmOut.bankSelN == DMB_SEL_IDLE; endproperty
  a_idle: assert property (p_idle) else $error("control active while idle");
endmodule
bind dmb_data_memory_bus_interface dmb_data_memory_bus_interface_assertions u_chk (.mclk,
  .resetn, .dmOut, .dmAddrOe, .dmCtrlOe, .dm_acknowledge_n, .dm_float_ctrl_n,
  .bus_request_n, .bus_grant_n, .coreRespValid, .coreReqReady, .coreHalt);

// ---- tb/dmb_mem_model.sv ----
// dmb_mem_model: external data memory with a set number of wait states
// assumes registered pins from the port; 64 words, higher addresses alias
`timescale 1ns/1ns
module dmb_mem_model
  import dmb_pkg::*;
(
  input wire logic mclk,
  input dmb_pins_t pins,
  input wire logic ctrlOe,
  input wire logic dataOe,
  input wire logic [3:0] waits,
  output logic ackN,
  output logic [DMB_DATA_W-1:0] rdata
);
  logic [DMB_DATA_W-1:0] mem [0:63];
  logic [DMB_DATA_W-1:0] last = 40'h0000000000;
  int cnt = 0;
  // count survives a float so ack is already low when pins come back
  assign ackN = (cnt < waits);
  // released lines toggle instead of keeping a stale word
  assign rdata = (ctrlOe && !pins.readN) ? mem[pins.addr[5:0]] : ~last;
  always @(posedge mclk) begin
    last <= rdata;
    if (ctrlOe && !(pins.readN && pins.writeN)) cnt <= cnt + 1;
    else if (ctrlOe) cnt <= 0;
    if (dataOe && !pins.writeN) mem[pins.addr[5:0]] <= pins.data;
  end
endmodule

// ---- tb/dmb_data_memory_bus_interface_bench.sv ----
// bench: random accesses, float and bus grant against a reference memory
// assumes dmb_mem_model on the pins and the checker bound to the port
`timescale 1ns/1ns
module dmb_data_memory_bus_interface_bench
  import dmb_pkg::*;
;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic coreReqValid = 1'b0;
  logic dm_float_ctrl_n = 1'b1;
  logic bus_request_n = 1'b1;
  logic coreReqReady, coreRespValid, coreHalt, fetchStart, ackN, bus_grant_n, dm_page_cross;
  logic dmAddrOe, dmDataOe, dmCtrlOe;
  logic [DMB_DATA_W-1:0] coreRespData, dmDataIn;
  logic [23:0] fetchAddr;
  logic [3:0] waits = 4'h0;
  dmb_req_t coreReq = '0;
  dmb_cfg_t cfg = '{5'h00, 5'h1E, 4'hF};
  dmb_pins_t dmOut;
  logic [DMB_DATA_W-1:0] expMem [0:63];
  logic [31:0] wq [$];
  logic [31:0] prevAddr = 32'h00000000;
  bit havePrev = 0;
  int err_total = 0, checked = 0, floatLeft = 0, seed = 32'hF00E;
  dmb_data_memory_bus_interface DUT (.mclk, .resetn, .coreReqValid, .coreReq, .coreReqReady,
    .coreRespValid, .coreRespData, .coreHalt, .fetchStart, .fetchAddr, .cfg, .dmOut,
    .dmAddrOe, .dmDataOe, .dmCtrlOe, .dmDataIn, .dm_acknowledge_n(ackN), .dm_float_ctrl_n,
    .bus_request_n, .bus_grant_n, .dm_page_cross);
  dmb_mem_model MEM (.mclk, .pins(dmOut), .ctrlOe(dmCtrlOe), .dataOe(dmDataOe), .waits,
    .ackN, .rdata(dmDataIn));
  always #20 mclk = ~mclk;
  // float is pulsed only inside an access
  always @(posedge mclk) begin
    dm_float_ctrl_n <= (floatLeft == 0);
    if (floatLeft > 0) floatLeft--;
  end
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic acc(input bit wr, input logic [31:0] a, input int w, input bit fl);
    logic [39:0] d;
    logic [3:0] sel;
    bit pg;
    bit hlt;
    int n;
    @(posedge mclk);
    d = {$random(seed), 8'h00};
    sel = cfg.bankEnable[a[31:30]] ? ~(4'h1 << a[31:30]) : DMB_SEL_IDLE;
    pg = havePrev && cfg.pageShift != DMB_NO_PAGES
      && (a >> cfg.pageShift) != (prevAddr >> cfg.pageShift);
    havePrev = 1;
    prevAddr = a;
    hlt = 0;
    n = 0;
    coreReqValid <= 1'b1;
    coreReq <= '{wr, a, d};
    waits <= 4'(w);
    do begin @(negedge mclk); n++; end while (coreReqReady !== 1'b1 && n < 20);
    chk(40'(coreReqReady), 40'h1);
    @(posedge mclk);
    coreReqValid <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
      hlt |= coreHalt === 1'b1;
      if (n == 1) begin
        chk(40'({dmOut.readN, dmOut.writeN}), 40'({wr, !wr}));
        chk(40'(dmOut.addr), 40'(a));
        chk(40'({dmAddrOe, dmCtrlOe, dmDataOe}), 40'({2'b11, wr}));
        chk(40'(dmOut.bankSelN), 40'(sel));
        chk(40'(dm_page_cross), 40'(pg));
        if (wr) chk(dmOut.data, d);
        if (fl) floatLeft = 3;
      end
    end while (coreRespValid !== 1'b1 && n < 40);
    chk(40'(coreRespValid), 40'h1);
    // three floated cycles plus the release cycle in which ack is not yet looked at
    if (fl) chk(40'(n), 40'(w + 5));
    if (fl) chk(40'(hlt), 40'h1);
    else chk(40'(n), 40'(2 + w));
    if (wr) begin
      expMem[a[5:0]] = d;
      wq.push_back(a);
    end else chk(coreRespData, expMem[a[5:0]]);
  endtask
  task automatic grab;
    int n;
    @(posedge mclk);
    bus_request_n <= 1'b0;
    n = 0;
    do begin @(negedge mclk); n++; end while (bus_grant_n !== 1'b0 && n < 10);
    // two synchroniser flops, then one registered cycle in idle
    chk(40'(n), 40'h4);
    chk(40'({dmAddrOe, dmCtrlOe, coreHalt}), 40'h1);
    repeat (4) @(negedge mclk);
    chk(40'(bus_grant_n), 40'h0);
    @(posedge mclk);
    bus_request_n <= 1'b1;
    n = 0;
    do begin @(negedge mclk); n++; end while (bus_grant_n !== 1'b1 && n < 10);
    chk(40'(bus_grant_n), 40'h1);
    chk(40'(n), 40'h4);
    chk(40'({dmAddrOe, dmCtrlOe, coreHalt}), 40'h6);
  endtask
  initial begin
    int w;
    repeat (3) @(posedge mclk);
    chk(40'({dmCtrlOe, bus_grant_n}), 40'h1);
    resetn <= 1'b1;
    @(negedge mclk);
    @(negedge mclk);
    chk(40'({fetchStart, fetchAddr}), 40'({1'b1, DMB_RESET_VECTOR}));
    for (int i = 0; i < 60; i++) begin
      @(posedge mclk);
      cfg.pageShift <= (i % 4 == 0) ? DMB_NO_PAGES : 5'($unsigned($random(seed)) % 8 + 1);
      cfg.bankEnable <= 4'($random(seed));
      w = (i == 30) ? 2 : $unsigned($random(seed)) % 4;
      if (i == 40) grab(); // resumes with the next access
      if (i < 8 || $random(seed) % 2) acc(1'b1, $random(seed) & 32'hC000003F, w, i == 30);
      else acc(1'b0, wq[$unsigned($random(seed)) % wq.size()], w, i == 30);
    end
    report_and_stop();
  end
  initial begin
    #400000;
    err_total++;
    report_and_stop();
  end
endmodule
